// *** core/dbg_port_pkg.sv ***
// Constants and types shared by the debug and boundary-scan port.
// Assumes one core clock; every pin input is asynchronous to it.
package dbg_port_pkg;

   // Test-access controller states
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
      TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
      TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } tap_state_e;

   // Instruction register layout and codes
   localparam int          IR_W        = 4;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;
   localparam logic [3:0]  IR_IDCODE   = 4'h1;
   localparam logic [3:0]  IR_BYPASS   = 4'hf;

   // Identification register; value is arbitrary
   localparam int          ID_W        = 32;
   localparam logic [31:0] ID_VALUE    = 32'h0000_1001;

   // Debug serial packet length in bits
   localparam int          PKT_W       = 17;

   // Processor status codes
   localparam logic [3:0]  PST_HALTED  = 4'hf;
   localparam logic [3:0]  PST_RESET   = 4'h0;

   // Link timing: status clock period and least serial clock period
   localparam int          PST_CLK_NS  = 4;
   localparam int          DEBUG_SERIAL_CLOCK_DIV   = 5;
   localparam int          DEBUG_SERIAL_CLOCK_MIN_NS = PST_CLK_NS * DEBUG_SERIAL_CLOCK_DIV;

endpackage : dbg_port_pkg

// *** core/dbg_port.sv ***
// Debug and boundary-scan test port: test-access controller, debug
// serial port, breakpoint request handling and processor status drive.
// Assumes every pin input is asynchronous to mclk_i, that the test clock
// runs well below mclk_i/4 and that the core reports instruction ends.
module dbg_port
   import dbg_port_pkg::*;
#(
   parameter int PKT_BITS = PKT_W
) (
   input  wire logic                mclk_i,
   input  wire logic                rstn_i,
   input  wire logic                port_select_i,
   input  wire logic                test_reset_n_i,
   input  wire logic                tclk_i,
   input  wire logic                tms_i,
   input  wire logic                tdi_i,
   output logic                     tdo_o,
   output logic                     tdo_oe_n_o,
   input  wire logic                debug_serial_clock_i,
   input  wire logic                debug_serial_in_i,
   output logic                     debug_serial_out_o,
   input  wire logic [PKT_BITS-1:0] packet_tx_i,
   output logic [PKT_BITS-1:0]      packet_rx_o,
   output logic                     packet_rx_valid_o,
   input  wire logic                breakpoint_request_i,
   input  wire logic                breakpoint_disable_bit_i,
   input  wire logic                instr_done_i,
   input  wire logic                resume_i,
   input  wire logic [3:0]          core_status_i,
   output logic [3:0]               processor_status_out_o,
   output logic                     halted_o,
   output logic                     debug_irq_o
);

   localparam int CW = $clog2(PKT_BITS + 1);

   typedef struct packed {
      // Pin synchronisers
      logic [1:0]          sel_sync;
      logic [1:0]          trst_sync;
      logic [2:0]          tclk_sync;
      logic [1:0]          tms_sync;
      logic [1:0]          tdi_sync;
      logic [2:0]          debug_serial_clock_sync;
      logic [1:0]          dsi_sync;
      logic [2:0]          breakpoint_request_sync;
      // Port ownership
      logic                jtag_sel;
      // Test-access controller
      tap_state_e          tap;
      logic [IR_W-1:0]     ir;
      logic [IR_W-1:0]     ir_shift;
      logic [ID_W-1:0]     dr_shift;
      logic                tdo;
      logic                tdo_oe_n;
      // Debug serial port
      logic                debug_serial_clock_valid;
      logic [PKT_BITS-1:0] rx_shift;
      logic [PKT_BITS-1:0] tx_shift;
      logic [CW-1:0]       bit_cnt;
      logic [PKT_BITS-1:0] rx_packet;
      logic                rx_valid;
      logic                debug_serial_out;
      // Breakpoint and status
      logic                breakpoint_request_pending;
      logic                halted;
      logic                dbg_irq;
      logic [3:0]          pst;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // Standard controller walk on one TMS sample
   function automatic tap_state_e tap_step(input tap_state_e s,
                                           input logic tms);
      case (s)
         TAP_RESET:    tap_step = tms ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   tap_step = tms ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: tap_step = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tap_step = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: tap_step = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   tap_step = tms ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: tap_step = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tap_step = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: tap_step = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         default:      tap_step = TAP_RESET;
      endcase
   endfunction

   // Edge flags from the last two synchronised samples
   logic tclk_rise;
   logic tclk_fall;
   logic ds_rise;
   logic breakpoint_request_rise;
   logic tap_hold;
   logic shifting;

   always_comb begin
      tclk_rise = state_reg.tclk_sync[1] & ~state_reg.tclk_sync[2];
      tclk_fall = ~state_reg.tclk_sync[1] & state_reg.tclk_sync[2];
      // Level accepted once two consecutive samples agree
      ds_rise   = ~state_reg.debug_serial_clock_valid & state_reg.debug_serial_clock_sync[1]
                  & state_reg.debug_serial_clock_sync[2];
      breakpoint_request_rise = state_reg.breakpoint_request_sync[1] & ~state_reg.breakpoint_request_sync[2];
      // Controller idles in reset when test reset is low or not selected
      tap_hold  = ~state_reg.trst_sync[1] | ~state_reg.jtag_sel;
      shifting  = (state_reg.tap == TAP_SHIFT_IR)
                  | (state_reg.tap == TAP_SHIFT_DR);
   end

   // Next-state logic for the whole port
   always_comb begin
      state_next = state_reg;
      state_next.sel_sync   = {state_reg.sel_sync[0], port_select_i};
      state_next.trst_sync  = {state_reg.trst_sync[0], test_reset_n_i};
      state_next.tclk_sync  = {state_reg.tclk_sync[1:0], tclk_i};
      state_next.tms_sync   = {state_reg.tms_sync[0], tms_i};
      state_next.tdi_sync   = {state_reg.tdi_sync[0], tdi_i};
      state_next.debug_serial_clock_sync = {state_reg.debug_serial_clock_sync[1:0],
                               debug_serial_clock_i};
      state_next.dsi_sync   = {state_reg.dsi_sync[0], debug_serial_in_i};
      state_next.breakpoint_request_sync  = {state_reg.breakpoint_request_sync[1:0],
                               breakpoint_request_i};
      state_next.rx_valid   = 1'b0;
      state_next.dbg_irq    = 1'b0;

      // Test-access controller on test clock edges
      if (tap_hold) begin
         state_next.tap      = TAP_RESET;
         state_next.ir       = IR_IDCODE;
         state_next.tdo_oe_n = 1'b1;
      end else if (tclk_rise) begin
         state_next.tap = tap_step(state_reg.tap,
                                   state_reg.tms_sync[1]);
         case (state_reg.tap)
            TAP_RESET:    state_next.ir = IR_IDCODE;
            TAP_CAP_IR:   state_next.ir_shift = IR_CAPTURE;
            TAP_SHIFT_IR: state_next.ir_shift = {state_reg.tdi_sync[1],
                             state_reg.ir_shift[IR_W-1:1]};
            TAP_UPD_IR:   state_next.ir = state_reg.ir_shift;
            TAP_CAP_DR:   state_next.dr_shift =
                             (state_reg.ir == IR_IDCODE) ? ID_VALUE : '0;
            TAP_SHIFT_DR: begin
               if (state_reg.ir == IR_IDCODE) begin
                  state_next.dr_shift = {state_reg.tdi_sync[1],
                     state_reg.dr_shift[ID_W-1:1]};
               end else begin
                  state_next.dr_shift[0] = state_reg.tdi_sync[1];
               end
            end
            default: ;
         endcase
      end else if (tclk_fall) begin
         // Output and its enable move on the falling edge; hold also forces the enable high
         state_next.tdo_oe_n = ~shifting;
         state_next.tdo = (state_reg.tap == TAP_SHIFT_IR)
                          ? state_reg.ir_shift[0]
                          : state_reg.dr_shift[0];
      end

      // Debug serial port, only when the debug module owns the pins
      if (state_reg.debug_serial_clock_sync[1] == state_reg.debug_serial_clock_sync[2]) begin
         state_next.debug_serial_clock_valid = state_reg.debug_serial_clock_sync[2];
      end
      if (!state_reg.jtag_sel && ds_rise) begin
         state_next.rx_shift = {state_reg.rx_shift[PKT_BITS-2:0],
                                state_reg.dsi_sync[1]};
         state_next.debug_serial_out = state_reg.tx_shift[PKT_BITS-1];
         state_next.tx_shift = {state_reg.tx_shift[PKT_BITS-2:0],
                                1'b0};
         if (state_reg.bit_cnt == CW'(PKT_BITS - 1)) begin
            state_next.bit_cnt   = '0;
            state_next.rx_packet = {state_reg.rx_shift[PKT_BITS-2:0],
                                    state_reg.dsi_sync[1]};
            state_next.rx_valid  = 1'b1;
            state_next.tx_shift  = packet_tx_i;
         end else begin
            state_next.bit_cnt = state_reg.bit_cnt + CW'(1);
         end
      end

      // Breakpoint: latch one request per assertion, act at instr end
      if (breakpoint_request_rise && !state_reg.halted) begin
         state_next.breakpoint_request_pending = 1'b1;
      end
      if (state_reg.breakpoint_request_pending && instr_done_i) begin
         state_next.breakpoint_request_pending = 1'b0;
         if (breakpoint_disable_bit_i) begin
            state_next.dbg_irq = 1'b1;
         end else begin
            state_next.halted = 1'b1;
         end
      end else if (state_reg.halted && resume_i) begin
         state_next.halted = 1'b0;
      end

      // Status registered every core clock
      state_next.pst = state_next.halted ? PST_HALTED
                                          : core_status_i;

      // Synchronous reset; port owner caught from the select strap
      if (!rstn_i) begin
         state_next = '0;
         state_next.sel_sync  = {state_reg.sel_sync[0], port_select_i};
         state_next.jtag_sel  = state_reg.sel_sync[1];
         state_next.tap       = TAP_RESET;
         state_next.ir        = IR_IDCODE;
         state_next.tdo_oe_n  = 1'b1;
         state_next.pst       = PST_RESET;
      end
   end

   // Single state register
   always_ff @(posedge mclk_i) begin
      state_reg <= state_next;
   end

   // Outputs straight from flip-flops
   assign tdo_o                  = state_reg.tdo;
   assign tdo_oe_n_o             = state_reg.tdo_oe_n;
   assign debug_serial_out_o     = state_reg.debug_serial_out;
   assign packet_rx_o            = state_reg.rx_packet;
   assign packet_rx_valid_o      = state_reg.rx_valid;
   assign processor_status_out_o = state_reg.pst;
   assign halted_o               = state_reg.halted;
   assign debug_irq_o            = state_reg.dbg_irq;

endmodule // dbg_port

// *** bench/dbg_port_properties.sv ***
// Pin timing checker for the debug and boundary-scan port.
// Assumes one core clock domain; bound to every dbg_port instance.
module dbg_port_properties
   import dbg_port_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   input wire logic       test_reset_n_i,
   input wire logic       tclk_i,
   input wire logic       tdo_o,
   input wire logic       tdo_oe_n_o,
   input wire logic       debug_serial_clock_i,
   input wire logic       debug_serial_out_o,
   input wire logic       packet_rx_valid_o,
   input wire logic       breakpoint_disable_bit_i,
   input wire logic       instr_done_i,
   input wire logic [3:0] core_status_i,
   input wire logic [3:0] processor_status_out_o,
   input wire logic       halted_o,
   input wire logic       debug_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   // Test-reset hold and the end of a completed instruction
   sequence s_trst_low; !test_reset_n_i [*4]; endsequence
   sequence s_done(bkd); $past(instr_done_i) && $past(bkd); endsequence

   property p_trst; s_trst_low |-> tdo_oe_n_o; endproperty
   a_trst: assert property (p_trst) else $error("tdo driven in reset");
   property p_tdo; $changed(tdo_o) |-> !$past(tclk_i) && !$past(tclk_i, 2);
   endproperty
   a_tdo: assert property (p_tdo) else $error("tdo moved off fall");
   property p_oe; $changed(tdo_oe_n_o) |-> !$past(tclk_i) && !$past(tclk_i, 2);
   endproperty
   a_oe: assert property (p_oe) else $error("tdo enable off fall");
   property p_dso; $changed(debug_serial_out_o) |->
      $past(debug_serial_clock_i) && $past(debug_serial_clock_i, 2); endproperty
   a_dso: assert property (p_dso) else $error("serial out early");
   property p_rxv; packet_rx_valid_o |=> !packet_rx_valid_o; endproperty
   a_rxv: assert property (p_rxv) else $error("rx valid too long");
   property p_halt; $rose(halted_o) |-> s_done(!breakpoint_disable_bit_i);
   endproperty
   a_halt: assert property (p_halt) else $error("halt without done");
   property p_irq; $rose(debug_irq_o) |->
      s_done(breakpoint_disable_bit_i) ##1 !debug_irq_o; endproperty
   a_irq: assert property (p_irq) else $error("bad debug irq");
   property p_pst_h; halted_o |-> processor_status_out_o == PST_HALTED;
   endproperty
   a_pst_h: assert property (p_pst_h) else $error("pst not f");
   property p_pst_c; !halted_o && $past(rstn_i) |->
      processor_status_out_o == $past(core_status_i); endproperty
   a_pst_c: assert property (p_pst_c) else $error("pst not core");
endmodule // dbg_port_properties

bind dbg_port dbg_port_properties dbg_port_properties_inst (.mclk_i,
   .rstn_i, .test_reset_n_i, .tclk_i, .tdo_o, .tdo_oe_n_o,
   .debug_serial_clock_i, .debug_serial_out_o, .packet_rx_valid_o,
   .breakpoint_disable_bit_i, .instr_done_i, .core_status_i,
   .processor_status_out_o, .halted_o, .debug_irq_o);

// *** bench/dbg_host.sv ***
// Model of the external tester and debug host on the port's pins.
// Assumes pins change just after mclk_i edges; 48 ns test clock and 56 ns serial clock periods.
module dbg_host
   import dbg_port_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_n_i,
   input  wire logic dso_i,
   output logic      tclk_o,
   output logic      tms_o,
   output logic      tdi_o,
   output logic      debug_serial_clock_o,
   output logic      dsi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 6; // 24 ns, far slower than status clock / 5

   // Idle levels; clocks stand low outside transfers
   initial {tclk_o, tms_o, tdi_o, debug_serial_clock_o, dsi_o} = 5'h08;

   // One test clock period; tdo sampled just before the rise
   task automatic tap_step(input logic tms, input logic tdi,
                           output logic tdo, output logic oe_n);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (HALF) @(posedge mclk_i);
      // Released pin has no pull: show the inverse of the last level
      tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;
      oe_n = tdo_oe_n_i;
      tclk_o <= 1'b1;
      repeat (HALF) @(posedge mclk_i);
      tclk_o <= 1'b0;
   endtask

   // One serial bit; output read after the clock falls
   task automatic ser_bit(input logic din, output logic dout);
      dsi_o <= din;
      repeat (HALF) @(posedge mclk_i);
      debug_serial_clock_o <= 1'b1;
      repeat (HALF) @(posedge mclk_i);
      debug_serial_clock_o <= 1'b0;
      repeat (2) @(posedge mclk_i);
      dout = dso_i;
   endtask

   // Whole packet, most significant bit first
   task automatic ser_word(input logic [PKT_W-1:0] w,
                           output logic [PKT_W-1:0] r);
      for (int i = PKT_W - 1; i >= 0; i--) ser_bit(w[i], r[i]);
   endtask
endmodule // dbg_host

// *** bench/testbench.sv ***
// Self-checking bench: serial link, breakpoint, then test access port.
// Assumes dbg_host drives the link pins; every run ends in test_done.
module testbench
   import dbg_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             mclk, rstn, sel, trst_n, tclk, tms, tdi, tdo, oe_n;
   logic             debug_serial_clock, dsi, debug_serial_out, rx_valid, breakpoint_request, bkd, done, resume;
   logic             halted, irq;
   logic [3:0]       core, pst;
   logic [PKT_W-1:0] tx, rx;
   int               errors, checks;
   int               n_valid = 0;
   int               n_irq = 0;

   dbg_port dbg_port_inst (.mclk_i(mclk), .rstn_i(rstn), .port_select_i(sel),
      .test_reset_n_i(trst_n), .tclk_i(tclk), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_n_o(oe_n), .debug_serial_clock_i(debug_serial_clock),
      .debug_serial_in_i(dsi), .debug_serial_out_o(debug_serial_out), .packet_tx_i(tx),
      .packet_rx_o(rx), .packet_rx_valid_o(rx_valid),
      .breakpoint_request_i(breakpoint_request), .breakpoint_disable_bit_i(bkd),
      .instr_done_i(done), .resume_i(resume), .core_status_i(core),
      .processor_status_out_o(pst), .halted_o(halted), .debug_irq_o(irq));
   dbg_host dbg_host_inst (.mclk_i(mclk), .tdo_i(tdo), .tdo_oe_n_i(oe_n),
      .dso_i(debug_serial_out), .tclk_o(tclk), .tms_o(tms), .tdi_o(tdi), .debug_serial_clock_o(debug_serial_clock),
      .dsi_o(dsi));

   // Clock and pulse counters
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) n_valid <= n_valid + (rx_valid === 1'b1);
   always @(posedge mclk) n_irq <= n_irq + (irq === 1'b1);

   task automatic check(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic do_reset(input logic s);
      rstn <= 1'b0;
      sel <= s;
      tick(3);
      rstn <= 1'b1;
      tick(4);
   endtask
   task automatic pulse_done;
      done <= 1'b1;
      tick(1);
      done <= 1'b0;
      tick(3);
   endtask
   task automatic tap_run(input int n, input logic [63:0] tmsv, tdiv,
                          output logic [63:0] tdov);
      logic o;
      for (int i = 0; i < n; i++)
         dbg_host_inst.tap_step(tmsv[i], tdiv[i], tdov[i], o);
      tick(4);
   endtask

   task automatic test_serial;
      logic [PKT_W-1:0] r;
      logic [63:0]      v;
      do_reset(1'b0);
      tx <= 17'h1a5c3;
      dbg_host_inst.ser_word(17'h0f0f1, r);
      check("packet_rx", 17'h0f0f1, rx);
      sel <= 1'b1;
      dbg_host_inst.ser_word(17'h10203, r);
      check("serial_out", 17'h1a5c3, r);
      check("packet_rx", 17'h10203, rx);
      check("rx_valid", 2, n_valid);
      tap_run(4, 4'b0010, 0, v);
      check("tdo_oe_n", 1, oe_n);
      $display("test serial done");
   endtask

   task automatic test_break;
      core <= 4'h5;
      breakpoint_request <= 1'b1;
      tick(6);
      check("halted", 0, halted);
      pulse_done();
      check("halted", 1, halted);
      check("pst", PST_HALTED, pst);
      core <= 4'ha;
      breakpoint_request <= 1'b0;
      tick(4);
      breakpoint_request <= 1'b1;
      tick(5);
      pulse_done();
      resume <= 1'b1;
      tick(1);
      resume <= 1'b0;
      tick(3);
      check("pst", 4'ha, pst);
      pulse_done();
      check("halted", 0, halted);
      breakpoint_request <= 1'b0;
      bkd <= 1'b1;
      tick(4);
      breakpoint_request <= 1'b1;
      tick(5);
      pulse_done();
      check("debug_irq", 1, n_irq);
      check("halted", 0, halted);
      {breakpoint_request, bkd} <= 2'b00;
      $display("test break done");
   endtask

   task automatic test_scan;
      logic [PKT_W-1:0] r;
      logic [63:0]      v;
      do_reset(1'b1);
      tap_run(4, 4'b0010, 0, v);
      check("tdo_oe_n", 0, oe_n);
      trst_n <= 1'b0;
      tick(5);
      check("tdo_oe_n", 1, oe_n);
      trst_n <= 1'b1;
      tick(4);
      tap_run(37, {2'b11, 31'h0, 4'b0010}, 0, v);
      check("idcode", ID_VALUE, v[35:4]);
      tap_run(15, {6'h31, 9'h183}, {6'h08, 9'h0f0}, v);
      check("ir_capture", IR_CAPTURE, v[7:4]);
      check("bypass", 2'b10, v[13:12]);
      check("tdo_oe_n", 1, oe_n);
      dbg_host_inst.ser_word(17'h1ffff, r);
      check("serial_out", 0, debug_serial_out);
      check("packet_rx", 0, rx);
      check("rx_valid", 2, n_valid);
      $display("test scan done");
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence and watchdog
   initial begin
      {rstn, sel, trst_n, breakpoint_request, bkd, done, resume} = 7'h10;
      {core, tx, errors, checks} = '0;
      test_serial();
      test_break();
      test_scan();
      test_done();
   end
   initial begin
      #40000;
      errors++;
      test_done();
   end
endmodule // testbench
